// ---- verilog/spc_regs.v ----
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_regs (
  input wire CLK,                         // System clock, 40 MHz.
  input wire RST,                         // Synchronous reset, active high.
  input wire PSEL,                        // APB3 select.
  input wire PENABLE,                     // APB3 access phase.
  input wire PWRITE,                      // APB3 write when high.
  input wire [31:0] PADDR,                // APB3 byte address.
  input wire [31:0] PWDATA,               // APB3 write data.
  output wire [31:0] PRDATA,              // APB3 read data.
  output wire PREADY,                     // APB3 ready, always high.
  output wire PSLVERR,                    // APB3 error on unmapped address.
  input wire [`SPC_NUM_PC-1:0] PC_ADVANCE, // Per-timeslot instruction consumed.
  input wire [`SPC_FLAG_W-1:0] FLAG_SET,  // Per-bit flag set events.
  output wire [`SPC_NUM_PC*`SPC_PC_W-1:0] PC_VALUE, // Packed program counters.
  output wire [`SPC_NUM_PC-1:0] PC_ENABLE, // Per-timeslot enable.
  output reg [`SPC_FLAG_W-1:0] FLAG_STATUS // Interrupt flag register.
);

  wire access;
  wire wr;
  wire hit_status;
  wire hit_clear;
  wire [`SPC_NUM_PC-1:0] hit_low;
  wire [`SPC_NUM_PC-1:0] hit_high;
  wire [`SPC_NUM_PC-1:0] hit_ctrl;
  wire [`SPC_NUM_PC*32-1:0] pc_rd;
  reg [31:0] rdata;
  reg [31:0] next_rdata;
  reg slverr;
  reg next_slverr;
  reg [`SPC_FLAG_W-1:0] next_flags;
  integer k;

  // Zero-wait slave: setup and access phase each take one cycle.
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;
  assign PREADY = 1'b1;
  assign PRDATA = rdata;
  assign PSLVERR = slverr && access;
  assign hit_status = (PADDR == `SPC_ADDR_FLAGS_STATUS);
  assign hit_clear = (PADDR == `SPC_ADDR_FLAGS_CLEAR);

  genvar g;
  generate
    for (g = 0; g < `SPC_NUM_PC; g = g + 1)
    begin : gen_pc
      wire [31:0] base;
      wire [`SPC_PC_W-1:0] pc;
      wire en;
      assign base = `SPC_ADDR_PC0_JUMP_LOW + `SPC_PC_STRIDE * g;
      assign hit_low[g] = (PADDR == base + {28'h0000000, `SPC_SLOT_LOW});
      assign hit_high[g] = (PADDR == base + {28'h0000000, `SPC_SLOT_HIGH});
      assign hit_ctrl[g] = (PADDR == base + {28'h0000000, `SPC_SLOT_CTRL});
      // Jump registers read back the live counter's low byte.
      assign pc_rd[g*32 +: 32] =
        hit_low[g] ? {24'h000000, pc[`SPC_JUMP_MSB:0]} :
        hit_high[g] ? {24'h000000, pc[`SPC_JUMP_MSB:0]} :
        hit_ctrl[g] ? {31'h00000000, en} : 32'h00000000;
      assign PC_VALUE[g*`SPC_PC_W +: `SPC_PC_W] = pc;
      assign PC_ENABLE[g] = en;
      spc_pc_slot u_slot (
        .clk(CLK),
        .rst(RST),
        .jump_low(wr && hit_low[g]),
        .jump_high(wr && hit_high[g]),
        .ctrl_wr(wr && hit_ctrl[g]),
        .wdata(PWDATA),
        .advance(PC_ADVANCE[g]),
        .pc(pc),
        .enable(en)
      );
    end
  endgenerate

  always @*
  begin
    next_flags = FLAG_STATUS;
    if (wr && hit_clear)
    begin
      next_flags = FLAG_STATUS & ~PWDATA;
    end
    // Applied after the clear so a coincident set survives.
    next_flags = next_flags | FLAG_SET;
  end

  always @*
  begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    for (k = 0; k < `SPC_NUM_PC; k = k + 1)
    begin
      next_rdata = next_rdata | pc_rd[k*32 +: 32];
    end
    if (hit_status)
    begin
      next_rdata = FLAG_STATUS;
    end
    if (hit_clear)
    begin
      next_rdata = 32'h00000000;
    end
    if (!(hit_status || hit_clear || (|hit_low) || (|hit_high) || (|hit_ctrl)))
    begin
      next_slverr = 1'b1;
    end
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      FLAG_STATUS <= `SPC_FLAGS_RESET;
      rdata <= 32'h00000000;
      slverr <= 1'b0;
    end
    else
    begin
      FLAG_STATUS <= next_flags;
      // Read data is registered in the setup phase, ready for the access phase.
      if (PSEL && !PENABLE)
      begin
        rdata <= PWRITE ? 32'h00000000 : next_rdata;
        slverr <= next_slverr;
      end
    end
  end

endmodule // spc_regs

// ---- verilog/spc_defs.vh ----
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Register byte addresses on the APB3 host bus.
`define SPC_ADDR_PC0_JUMP_LOW 32'h40020040
`define SPC_ADDR_PC0_JUMP_HIGH 32'h40020044
`define SPC_ADDR_PC0_CONTROL 32'h40020048
`define SPC_PC_STRIDE 32'h00000010
`define SPC_ADDR_FLAGS_STATUS 32'h40021228
`define SPC_ADDR_FLAGS_CLEAR 32'h4002122C

// Register slot offsets within one program counter group.
`define SPC_SLOT_LOW 4'h0
`define SPC_SLOT_HIGH 4'h4
`define SPC_SLOT_CTRL 4'h8

// Field layout.
`define SPC_JUMP_MSB 7
`define SPC_PC_W 9
`define SPC_HIGH_BASE 9'h100
`define SPC_CTRL_EN_BIT 0
`define SPC_NUM_PC 3
`define SPC_FLAG_W 32

// Reset values.
`define SPC_PC_RESET 9'h000
`define SPC_EN_RESET 1'h0
`define SPC_FLAGS_RESET 32'h00000000

`endif

// ---- verilog/spc_pc_slot.v ----
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_pc_slot (
  input wire clk,                         // System clock.
  input wire rst,                         // Synchronous reset, active high.
  input wire jump_low,                    // Write pulse to the low jump register.
  input wire jump_high,                   // Write pulse to the high jump register.
  input wire ctrl_wr,                     // Write pulse to the control register.
  input wire [31:0] wdata,                // Bus write data.
  input wire advance,                     // Sequencer consumed one instruction.
  output reg [`SPC_PC_W-1:0] pc,          // Next instruction address.
  output reg enable                       // Counter runs while high.
);

  reg [`SPC_PC_W-1:0] next_pc;

  always @*
  begin
    next_pc = pc;
    if (jump_low)
    begin
      next_pc = {1'b0, wdata[`SPC_JUMP_MSB:0]};
    end
    else if (jump_high)
    begin
      next_pc = `SPC_HIGH_BASE + {1'b0, wdata[`SPC_JUMP_MSB:0]};
    end
    else if (enable && advance)
    begin
      // A running counter wraps at the top of the 512-entry RAM.
      next_pc = pc + 9'h001;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      pc <= `SPC_PC_RESET;
      enable <= `SPC_EN_RESET;
    end
    else
    begin
      pc <= next_pc;
      if (ctrl_wr)
      begin
        enable <= wdata[`SPC_CTRL_EN_BIT];
      end
    end
  end

endmodule // spc_pc_slot

// ---- test/spc_regs_asserts.sv ----
`timescale 1ns/1ps
module spc_regs_chk (
  input logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, // Bus.
  input logic [31:0] PADDR, PWDATA, PRDATA, FLAG_SET, FLAG_STATUS, // Bus and flags.
  input logic [2:0] PC_ADVANCE, PC_ENABLE, // Timeslots.
  input logic [26:0] PC_VALUE // Counters.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire wr = PSEL && PENABLE && PWRITE;
  wire clr = wr && PADDR == 32'h4002122C;
  wire [7:0] wb = PWDATA[7:0];
  wire [31:0] gone = PWDATA & ~FLAG_SET;
  wire [31:0] keep = (FLAG_STATUS | FLAG_SET) & ~PWDATA;
  clr_one_a: assert property (clr |=> !(FLAG_STATUS & $past(gone)))
    else $error("flag not cleared");
  clr_zero_a: assert property (clr |=> (FLAG_STATUS & ~$past(PWDATA)) == $past(keep))
    else $error("flag changed");
  set_wins_a: assert property (1 |=> (FLAG_STATUS & $past(FLAG_SET)) == $past(FLAG_SET))
    else $error("set lost");
  jump_low_a: assert property (wr && PADDR == 32'h40020040 |=> PC_VALUE[8:0] == {1'b0, $past(wb)})
    else $error("low jump");
  jump_high_a: assert property (wr && PADDR == 32'h40020054 |=> PC_VALUE[17:9] == {1'b1, $past(wb)})
    else $error("high jump");
  ctrl_bit_a: assert property (wr && PADDR == 32'h40020068 |=> PC_ENABLE[2] == $past(wb[0]))
    else $error("enable");
  stop_hold_a: assert property (!PC_ENABLE[0] && !wr |=> $stable(PC_VALUE[8:0]))
    else $error("stopped counter moved");
  pc_step_a: assert property (PC_ENABLE[0] && PC_ADVANCE[0] && !wr |=>
    PC_VALUE[8:0] == $past(PC_VALUE[8:0]) + 9'h001) else $error("step");
  clr_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 32'h4002122C |=>
    PRDATA == 32'h00000000) else $error("clear read");
  cover property (clr && |(FLAG_SET & PWDATA));
  cover property (PC_ENABLE[0] && PC_ADVANCE[0]);
  cover property (wr && PADDR == 32'h40020054);
endmodule // spc_regs_chk
bind spc_regs spc_regs_chk u_chk (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
  logic [31:0] PADDR = 0, PWDATA = 0, FLAG_SET = 0, PRDATA, FLAG_STATUS, rd;
  logic [2:0] PC_ADVANCE = 0, PC_ENABLE;
  logic [26:0] PC_VALUE;
  int bad_count = 0, compares = 0, cycles = 0;
  spc_regs dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PC_ADVANCE(PC_ADVANCE), .FLAG_SET(FLAG_SET), .PC_VALUE(PC_VALUE),
    .PC_ENABLE(PC_ENABLE), .FLAG_STATUS(FLAG_STATUS));
  always #12.5 CLK = ~CLK;
  task end_sim;
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      end_sim();
    end
  end
  // An idle cycle separates transfers so no strobe is driven twice in one step.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK) #1 {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {2'b10, w, a, d};
    @(posedge CLK) #1 PENABLE = 1;
    @(posedge CLK) {rd, err} = {PRDATA, PSLVERR};
    #1 {PSEL, PENABLE} = 2'b00;
  endtask
  task t_flags;
    FLAG_SET = 32'hFFFFFFFF;
    @(posedge CLK) #1 FLAG_SET = 32'h0;
    bus(1, 32'h4002122C, 32'h0000FFFF);
    `CHK("clear", 32'hFFFF0000, FLAG_STATUS)
    bus(0, 32'h4002122C, 32'h0);
    `CHK("clr_rd", 32'h0, rd)
    `CHK("no_side", 32'hFFFF0000, FLAG_STATUS)
    FLAG_SET = 32'h00010000;
    bus(1, 32'h4002122C, 32'hFFFFFFFF);
    FLAG_SET = 32'h0;
    `CHK("set_wins", 32'h00010000, FLAG_STATUS)
  endtask
  task t_misc;
    bus(0, 32'h40021228, 32'h0);
    `CHK("status_rd", 32'h00010000, rd)
    `CHK("ready", 1'b1, PREADY)
    bus(1, 32'h40020058, 32'h1);
    bus(0, 32'h40020058, 32'h0);
    `CHK("ctrl_rd", 32'h00000001, rd)
    `CHK("ctrl_err", 1'b0, err)
    bus(1, 32'h40020030, 32'hFF);
    `CHK("slverr", 1'b1, err)
    `CHK("no_wr", 27'h0, PC_VALUE)
    bus(1, 32'h40021228, 32'h0);
    `CHK("ro_status", 32'h00010000, FLAG_STATUS)
    @(posedge CLK) #1 RST = 1;
    @(posedge CLK) #1 RST = 0;
    `CHK("rst_en", 3'h0, PC_ENABLE)
    `CHK("rst_flags", 32'h0, FLAG_STATUS)
  endtask
  task t_pc;
    logic [31:0] b;
    for (int g = 0; g < 3; g++)
    begin
      b = 32'h40020040 + 32'h10 * g;
      bus(1, b, 32'h1FF);
      `CHK("low", 9'h0FF, PC_VALUE[g*9+:9])
      bus(1, b + 4, 32'h0);
      `CHK("high0", 9'h100, PC_VALUE[g*9+:9])
      bus(1, b + 4, 32'hFF);
      `CHK("high", 9'h1FF, PC_VALUE[g*9+:9])
      bus(1, b + 8, 32'h3);
      `CHK("en", 1'b1, PC_ENABLE[g])
      PC_ADVANCE[g] = 1;
      @(posedge CLK) #1 PC_ADVANCE[g] = 0;
      `CHK("wrap", 9'h000, PC_VALUE[g*9+:9])
      bus(1, b + 8, 32'h2);
      `CHK("stop", 1'b0, PC_ENABLE[g])
      PC_ADVANCE[g] = 1;
      @(posedge CLK) #1 PC_ADVANCE[g] = 0;
      `CHK("held", 9'h000, PC_VALUE[g*9+:9])
    end
  endtask
  initial
  begin
    repeat (4) @(posedge CLK);
    #1 RST = 0;
    `CHK("rst_pc", 27'h0, PC_VALUE)
    t_flags;
    t_pc;
    t_misc;
    end_sim();
  end
endmodule // tb
